// [shared/frc_pkg.sv]
// Purpose: constants shared by the reset-controlled shift-register fifo
// Assumes: one system clock, AXI4-Lite register access
// Notes:   offsets are byte addresses of aligned 32-bit words
package frc_pkg;
    // register byte offsets
    localparam logic [7:0] OFF_CTRL   = 8'h00;
    localparam logic [7:0] OFF_PFULL  = 8'h04;
    localparam logic [7:0] OFF_PEMPTY = 8'h08;
    localparam logic [7:0] OFF_STATUS = 8'h0c;
    localparam logic [7:0] OFF_EVENTS = 8'h10;
    // control fields
    localparam int CTRL_SOFT_RST = 0;
    // status fields
    localparam int ST_EMPTY  = 0;
    localparam int ST_FULL   = 1;
    localparam int ST_AEMPTY = 2;
    localparam int ST_AFULL  = 3;
    localparam int ST_PEMPTY = 4;
    localparam int ST_PFULL  = 5;
    localparam int ST_IN_RST = 6;
    localparam int ST_COUNT  = 8;
    // sticky event fields
    localparam int EV_OVF = 0;
    localparam int EV_UNF = 1;
    // reset sequencing
    localparam int SYNC_STAGES = 3;
    localparam int PRIM_STAGES = 5;
    // axi responses
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // memory kinds and reset modes
    typedef enum logic [1:0] {
        MEM_SHIFT = 2'b00,
        MEM_BLOCK = 2'b01,
        MEM_DIST  = 2'b10,
        MEM_PRIM  = 2'b11
    } frc_mem_type;
    typedef enum logic [1:0] {
        RST_NONE  = 2'b00,
        RST_ASYNC = 2'b01,
        RST_SYNC  = 2'b10
    } frc_rst_type;
endpackage : frc_pkg

// [src/frc_fifo.sv]
// Purpose: common-clock fifo with selectable reset behaviour
// Assumes: all inputs synchronous to CLK_SYS except FIFO_RST
// Notes:   read side is standard mode, data one cycle after RD_EN
// Operation
// - one up/down counter drives all flags
// - reset clears counters, outputs, memory
// - async reset release synchronised per domain
// - read while empty raises underflow
// - write while full raises overflow
// - full flags reset value is selectable
// - reset rising edge starts internal reset
// - reset assertion acts without any clock
// - synchronisation ends three cycles later
// - reset shows empty, zero count, inactive strobes
// - full flags one in reset, zero at power-up
// - full flags clear three cycles after release
// - zero option keeps full flags low
// - primitive variant stretches reset five cycles
// - primitive reset: not full, empty
// - primitive keeps last read data
// - primitive dout reset only with output register
// - sync reset offered for all listed memories
// - sync reset clears on the clock edge
// - each signal valid in its own domain
`timescale 1ns/10ps
module frc_fifo #(
    parameter int                   DW           = 8,
    parameter int                   DEPTH        = 16,
    parameter frc_pkg::frc_mem_type MEM_KIND     = frc_pkg::MEM_SHIFT,
    parameter frc_pkg::frc_rst_type RST_MODE     = frc_pkg::RST_ASYNC,
    parameter bit                   FULL_RST_ONE = 1'b1,
    parameter bit                   EMB_OUT_REG  = 1'b0,
    parameter bit                   VALID_LOW    = 1'b0,
    parameter bit                   ACK_LOW      = 1'b0,
    parameter logic [DW-1:0]        DOUT_RST_VAL = '0
) (
    input  wire logic          CLK_SYS,
    input  wire logic          RESET_N,
    input  wire logic          FIFO_RST,
    input  wire logic          FIFO_SRST,
    input  wire logic          WR_EN,
    input  wire logic [DW-1:0] DIN,
    output logic               FULL,
    output logic               ALMOST_FULL,
    output logic               PROG_FULL,
    output logic               WR_ACK,
    output logic               OVERFLOW,
    input  wire logic          RD_EN,
    output logic [DW-1:0]      DOUT,
    output logic               EMPTY,
    output logic               ALMOST_EMPTY,
    output logic               PROG_EMPTY,
    output logic               VALID,
    output logic               UNDERFLOW,
    output logic [7:0]         DATA_COUNT,
    input  wire logic [7:0]    S_AXI_AWADDR,
    input  wire logic          S_AXI_AWVALID,
    output logic               S_AXI_AWREADY,
    input  wire logic [31:0]   S_AXI_WDATA,
    input  wire logic [3:0]    S_AXI_WSTRB,
    input  wire logic          S_AXI_WVALID,
    output logic               S_AXI_WREADY,
    output logic [1:0]         S_AXI_BRESP,
    output logic               S_AXI_BVALID,
    input  wire logic          S_AXI_BREADY,
    input  wire logic [7:0]    S_AXI_ARADDR,
    input  wire logic          S_AXI_ARVALID,
    output logic               S_AXI_ARREADY,
    output logic [31:0]        S_AXI_RDATA,
    output logic [1:0]         S_AXI_RRESP,
    output logic               S_AXI_RVALID,
    input  wire logic          S_AXI_RREADY
);
    localparam int CW = $clog2(DEPTH + 1);
    localparam int LAST = (MEM_KIND == frc_pkg::MEM_PRIM) ?
                          frc_pkg::PRIM_STAGES - 1 : frc_pkg::SYNC_STAGES - 1;
    localparam logic [CW-1:0] CNT_FULL = CW'(DEPTH);
    localparam logic [CW-1:0] CNT_ONE  = CW'(1);
    localparam bit PRIM = (MEM_KIND == frc_pkg::MEM_PRIM);
    // the primitive only resets dout with its output register
    localparam bit DOUT_RST_OK = !PRIM || EMB_OUT_REG;

    // refused at elaboration: the counter and status word assume these bounds
    if (DEPTH < 2 || CW > 8 || DW < 1 || DW > 32) begin : g_bad_size
        $error("frc_fifo: unsupported width or depth");
    end
    // a disabled reset pin only suits block or distributed memory
    if (RST_MODE == frc_pkg::RST_NONE && MEM_KIND != frc_pkg::MEM_BLOCK
        && MEM_KIND != frc_pkg::MEM_DIST) begin : g_bad_reset
        $error("frc_fifo: reset may only be omitted for ram memories");
    end

    // asynchronous reset path: pin level enters only as a reset
    wire logic arst_n = RESET_N &
        !(RST_MODE == frc_pkg::RST_ASYNC && FIFO_RST);

    logic [frc_pkg::PRIM_STAGES-1:0] rst_pipe;
    logic                            por;
    logic                            soft_rst;

    // release chain; only tap LAST is looked at, which is the last tap only for the primitive
    always_ff @(posedge CLK_SYS or negedge arst_n) begin
        if (!arst_n) begin
            rst_pipe <= '1;
        end else begin
            rst_pipe <= {rst_pipe[frc_pkg::PRIM_STAGES-2:0], 1'b0};
        end
    end

    wire logic in_rst = rst_pipe[LAST];
    // power-on state is told apart so full flags start low
    always_ff @(posedge CLK_SYS or negedge RESET_N) begin
        if (!RESET_N) begin
            por <= 1'b1;
        end else if (!in_rst) begin
            por <= 1'b0;
        end
    end

    wire logic srst_hit = (RST_MODE == frc_pkg::RST_SYNC) && FIFO_SRST;
    // sync reset needs no extra stages on a single clock
    wire logic clr = in_rst || srst_hit || soft_rst;

    // storage and the single occupancy counter
    logic [DW-1:0] mem [DEPTH];
    logic [CW-1:0] cnt;
    logic [DW-1:0] dout_q;
    logic          valid_q;
    logic          ack_q;
    logic          ovf_q;
    logic          unf_q;

    wire logic cnt_full  = (cnt == CNT_FULL);
    wire logic cnt_empty = (cnt == '0);
    wire logic push      = WR_EN && !cnt_full && !clr;
    wire logic pop       = RD_EN && !cnt_empty && !clr;
    wire logic [CW-1:0] rd_idx = cnt - CNT_ONE;

    logic [CW-1:0] next_cnt;
    always_comb begin
        next_cnt = cnt;
        if (push && !pop) begin
            next_cnt = cnt + CNT_ONE;
        end else if (pop && !push) begin
            next_cnt = cnt - CNT_ONE;
        end
    end

    always_ff @(posedge CLK_SYS or negedge arst_n) begin
        if (!arst_n) begin
            cnt <= '0;
            for (int i = 0; i < DEPTH; i++) begin
                mem[i] <= '0;
            end
        end else if (clr) begin
            cnt <= '0;
            for (int i = 0; i < DEPTH; i++) begin
                mem[i] <= '0;
            end
        end else begin
            cnt <= next_cnt;
            if (push) begin
                mem[0] <= DIN;
                for (int i = 1; i < DEPTH; i++) begin
                    mem[i] <= mem[i-1];
                end
            end
        end
    end

    // strobes and error pulses follow the request by one cycle
    always_ff @(posedge CLK_SYS or negedge arst_n) begin
        if (!arst_n) begin
            valid_q <= 1'b0;
            ack_q   <= 1'b0;
            ovf_q   <= 1'b0;
            unf_q   <= 1'b0;
        end else begin
            valid_q <= pop;
            ack_q   <= push;
            ovf_q   <= WR_EN && cnt_full && !clr;
            unf_q   <= RD_EN && cnt_empty && !clr;
        end
    end

    // dout survives a fifo reset in the primitive variant without its output register
    always_ff @(posedge CLK_SYS or negedge RESET_N) begin
        if (!RESET_N) begin
            dout_q <= PRIM ? '0 : DOUT_RST_VAL;
        end else if (clr && DOUT_RST_OK) begin
            dout_q <= DOUT_RST_VAL;
        end else if (pop) begin
            dout_q <= mem[rd_idx[$clog2(DEPTH)-1:0]];
        end
    end

    // full-type flags forced high only outside power-up
    wire logic force_full = in_rst && !por && FULL_RST_ONE && !PRIM
                            && RST_MODE == frc_pkg::RST_ASYNC;

    logic [CW-1:0] pf_thresh;
    logic [CW-1:0] pe_thresh;

    assign FULL         = force_full || cnt_full;
    assign ALMOST_FULL  = force_full || (cnt >= CNT_FULL - CNT_ONE);
    // a zero threshold must not raise prog full while in reset
    assign PROG_FULL    = force_full || (!in_rst && cnt >= pf_thresh);
    assign EMPTY        = cnt_empty;
    assign ALMOST_EMPTY = (cnt <= CNT_ONE);
    assign PROG_EMPTY   = (cnt <= pe_thresh);
    assign DATA_COUNT   = 8'(cnt);
    assign DOUT         = dout_q;
    assign VALID        = valid_q ^ VALID_LOW;
    assign WR_ACK       = ack_q ^ ACK_LOW;
    assign OVERFLOW     = ovf_q;
    assign UNDERFLOW    = unf_q;

    // register slave: address and data may arrive in either order
    logic          aw_held;
    logic          w_held;
    logic [7:0]    aw_addr;
    logic [31:0]   w_data;
    logic [3:0]    w_strb;
    logic          bvalid;
    logic [1:0]    bresp;
    logic          rvalid;
    logic [31:0]   rdata;
    logic [1:0]    rresp;
    logic [1:0]    events;

    function automatic logic mapped(input logic [7:0] a);
        mapped = (a == frc_pkg::OFF_CTRL) || (a == frc_pkg::OFF_PFULL) ||
                 (a == frc_pkg::OFF_PEMPTY) || (a == frc_pkg::OFF_STATUS) ||
                 (a == frc_pkg::OFF_EVENTS);
    endfunction : mapped

    assign S_AXI_AWREADY = !aw_held && !bvalid;
    assign S_AXI_WREADY  = !w_held && !bvalid;
    assign S_AXI_ARREADY = !rvalid;
    assign S_AXI_BVALID  = bvalid;
    assign S_AXI_BRESP   = bresp;
    assign S_AXI_RVALID  = rvalid;
    assign S_AXI_RDATA   = rdata;
    assign S_AXI_RRESP   = rresp;

    wire logic do_wr = aw_held && w_held;
    wire logic wr_lo = do_wr && w_strb[0];
    wire logic wr_ctrl = wr_lo && aw_addr == frc_pkg::OFF_CTRL;
    wire logic wr_ev   = wr_lo && aw_addr == frc_pkg::OFF_EVENTS;

    wire logic [31:0] status_word =
        (32'(cnt) << frc_pkg::ST_COUNT) |
        (32'(in_rst) << frc_pkg::ST_IN_RST) |
        (32'(PROG_FULL) << frc_pkg::ST_PFULL) |
        (32'(PROG_EMPTY) << frc_pkg::ST_PEMPTY) |
        (32'(ALMOST_FULL) << frc_pkg::ST_AFULL) |
        (32'(ALMOST_EMPTY) << frc_pkg::ST_AEMPTY) |
        (32'(FULL) << frc_pkg::ST_FULL) |
        (32'(EMPTY) << frc_pkg::ST_EMPTY);

    logic [31:0] rd_word;
    always_comb begin
        rd_word = '0;
        unique case (S_AXI_ARADDR)
            frc_pkg::OFF_PFULL:  rd_word = 32'(pf_thresh);
            frc_pkg::OFF_PEMPTY: rd_word = 32'(pe_thresh);
            frc_pkg::OFF_STATUS: rd_word = status_word;
            frc_pkg::OFF_EVENTS: rd_word = 32'(events);
            default:             rd_word = '0;
        endcase
    end

    // events: hardware set wins over a same-cycle software clear
    wire logic [1:0] ev_set = {unf_q, ovf_q};
    wire logic [1:0] ev_clr = wr_ev ? w_data[1:0] : 2'b00;

    always_ff @(posedge CLK_SYS or negedge RESET_N) begin
        if (!RESET_N) begin
            aw_held   <= 1'b0;
            w_held    <= 1'b0;
            aw_addr   <= '0;
            w_data    <= '0;
            w_strb    <= '0;
            bvalid    <= 1'b0;
            bresp     <= frc_pkg::RESP_OKAY;
            rvalid    <= 1'b0;
            rdata     <= '0;
            rresp     <= frc_pkg::RESP_OKAY;
            soft_rst  <= 1'b0;
            pf_thresh <= CNT_FULL - CNT_ONE;
            pe_thresh <= CNT_ONE;
            events    <= '0;
        end else begin
            if (S_AXI_AWVALID && S_AXI_AWREADY) begin
                aw_held <= 1'b1;
                aw_addr <= S_AXI_AWADDR;
            end
            if (S_AXI_WVALID && S_AXI_WREADY) begin
                w_held <= 1'b1;
                w_data <= S_AXI_WDATA;
                w_strb <= S_AXI_WSTRB;
            end
            if (do_wr) begin
                aw_held <= 1'b0;
                w_held  <= 1'b0;
                bvalid  <= 1'b1;
                bresp   <= mapped(aw_addr) ? frc_pkg::RESP_OKAY : frc_pkg::RESP_SLVERR;
            end else if (bvalid && S_AXI_BREADY) begin
                bvalid <= 1'b0;
            end
            soft_rst <= wr_ctrl && w_data[frc_pkg::CTRL_SOFT_RST];
            if (wr_lo && aw_addr == frc_pkg::OFF_PFULL) begin
                pf_thresh <= w_data[CW-1:0];
            end
            if (wr_lo && aw_addr == frc_pkg::OFF_PEMPTY) begin
                pe_thresh <= w_data[CW-1:0];
            end
            events <= (events & ~ev_clr) | ev_set;
            if (S_AXI_ARVALID && S_AXI_ARREADY) begin
                rvalid <= 1'b1;
                rdata  <= rd_word;
                rresp  <= mapped(S_AXI_ARADDR) ? frc_pkg::RESP_OKAY : frc_pkg::RESP_SLVERR;
            end else if (rvalid && S_AXI_RREADY) begin
                rvalid <= 1'b0;
            end
        end
    end

    // checks next to the logic they guard
    a_count_step: assert property (@(posedge CLK_SYS) disable iff (!arst_n)
        !clr && !srst_hit |=> (cnt == $past(next_cnt)))
        else $error("occupancy counter stepped wrongly");

    a_underflow_flag: assert property (@(posedge CLK_SYS) disable iff (!arst_n)
        RD_EN && EMPTY && !clr |=> UNDERFLOW)
        else $error("underflow missing on empty read");

    a_overflow_flag: assert property (@(posedge CLK_SYS) disable iff (!arst_n)
        WR_EN && cnt_full && !clr |=> OVERFLOW &&
        (cnt == ($past(pop) ? CNT_FULL - CNT_ONE : CNT_FULL)))
        else $error("overflow missing on full write");

    a_release_three: assert property (@(posedge CLK_SYS) disable iff (!RESET_N)
        !PRIM && RST_MODE == frc_pkg::RST_ASYNC && $fell(FIFO_RST)
        |-> in_rst [*3] ##1 !in_rst)
        else $error("reset release not three cycles");

    a_stretch_five: assert property (@(posedge CLK_SYS) disable iff (!RESET_N)
        PRIM && RST_MODE == frc_pkg::RST_ASYNC && $fell(FIFO_RST)
        |-> in_rst [*5] ##1 !in_rst)
        else $error("primitive reset not stretched five");

    a_reset_state: assert property (@(posedge CLK_SYS) disable iff (!RESET_N)
        in_rst |-> EMPTY && PROG_EMPTY && DATA_COUNT == 8'h00 && VALID == VALID_LOW)
        else $error("reset output state wrong");

    a_full_one: assert property (@(posedge CLK_SYS) disable iff (!RESET_N)
        FULL_RST_ONE && !PRIM && RST_MODE == frc_pkg::RST_ASYNC && in_rst && !por
        |-> FULL && ALMOST_FULL && PROG_FULL)
        else $error("full flags not high during reset");

    a_full_zero: assert property (@(posedge CLK_SYS) disable iff (!RESET_N)
        (!FULL_RST_ONE || PRIM || por) && in_rst |-> !FULL && !PROG_FULL)
        else $error("full flags not low during reset");

    a_sync_clear: assert property (@(posedge CLK_SYS) disable iff (!arst_n)
        srst_hit || soft_rst |=> cnt == '0 && VALID == VALID_LOW && WR_ACK == ACK_LOW)
        else $error("sync reset did not clear on the edge");

    a_async_now: assert property (@(posedge CLK_SYS) disable iff (!RESET_N)
        RST_MODE == frc_pkg::RST_ASYNC && FIFO_RST |-> cnt == '0 && in_rst)
        else $error("async reset did not act at once");

endmodule : frc_fifo

// [sim/frc_port_model.sv]
// Purpose: producer and consumer logic facing the fifo data ports
// Assumes: bench raises req_wr/req_rd right after a rising edge
// Notes:   DIN shows the inverse of the last word while no write is offered
`timescale 1ns/10ps
module frc_port_model (
    input  wire logic       clk_sys,
    input  wire logic       reset_n,
    input  wire logic       fifo_rst,
    input  wire logic       full,
    input  wire logic       valid,
    input  wire logic [7:0] dout,
    input  wire logic       req_wr,
    input  wire logic       req_rd,
    input  wire logic [7:0] req_data,
    input  wire logic       push_full,
    output logic            wr_en,
    output logic [7:0]      din,
    output logic            rd_en,
    output logic [7:0]      got_data,
    output logic [7:0]      got_count
);
    logic [7:0] last_din;
    // requests held back in reset or when full; push_full breaks this on purpose
    assign wr_en = req_wr & ~fifo_rst & (push_full | ~full);
    assign rd_en = req_rd & ~fifo_rst;
    assign din   = wr_en ? req_data : ~last_din;
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            last_din  <= 8'h00;
            got_count <= 8'h00;
            got_data  <= 8'h00;
        end else begin
            if (wr_en) last_din <= req_data;
            if (valid) begin
                got_data  <= dout;
                got_count <= got_count + 8'h01;
            end
        end
    end
endmodule : frc_port_model

// [sim/tb_top.sv]
// Purpose: self-checking bench for the reset-controlled fifo
// Assumes: default build, shift memory, async reset, full flags reset to one
// Notes:   outputs are sampled at the falling edge, inputs change at the rising edge
`timescale 1ns/10ps
module tb_top;
    logic        clk_sys = 1'b0, reset_n = 1'b0, fifo_rst = 1'b0, push_full = 1'b0;
    logic        req_wr = 1'b0, req_rd = 1'b0;
    logic [7:0]  req_data = 8'h00, awaddr = 8'h00, araddr = 8'h00;
    logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic [31:0] wdata = 32'h0, rdata, rd;
    logic [1:0]  bresp, rresp, rsp;
    logic        awready, wready, bvalid, arready, rvalid, wr_en, rd_en;
    logic        full, afull, pfull, empty, aempty, pempty, wr_ack, ovf, valid, unf;
    logic [7:0]  din, dout, data_count, got_data, got_count;
    int          n_errors = 0, comparisons = 0, n_ack = 0, n_ovf = 0, n_unf = 0, cycles = 0;

    always #10 clk_sys = ~clk_sys;

    frc_fifo i_frc_fifo (.CLK_SYS(clk_sys), .RESET_N(reset_n), .FIFO_RST(fifo_rst),
        .FIFO_SRST(1'b0), .WR_EN(wr_en), .DIN(din), .FULL(full), .ALMOST_FULL(afull),
        .PROG_FULL(pfull), .WR_ACK(wr_ack), .OVERFLOW(ovf), .RD_EN(rd_en), .DOUT(dout),
        .EMPTY(empty), .ALMOST_EMPTY(aempty), .PROG_EMPTY(pempty), .VALID(valid),
        .UNDERFLOW(unf), .DATA_COUNT(data_count), .S_AXI_AWADDR(awaddr),
        .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata),
        .S_AXI_WSTRB(4'hf), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready),
        .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
        .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
        .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid),
        .S_AXI_RREADY(rready));

    frc_port_model i_frc_port_model (.clk_sys(clk_sys), .reset_n(reset_n),
        .fifo_rst(fifo_rst), .full(full), .valid(valid), .dout(dout), .req_wr(req_wr),
        .req_rd(req_rd), .req_data(req_data), .push_full(push_full), .wr_en(wr_en),
        .din(din), .rd_en(rd_en), .got_data(got_data), .got_count(got_count));

    // pulse counters: one-cycle strobes are easy to miss with spot checks
    always @(posedge clk_sys) begin
        cycles = cycles + 1;
        if (wr_ack === 1'b1) n_ack = n_ack + 1;
        if (ovf === 1'b1) n_ovf = n_ovf + 1;
        if (unf === 1'b1) n_unf = n_unf + 1;
        if (cycles == 3000) begin
            n_errors = n_errors + 1;
            tally_and_finish();
        end
    end

    task automatic tally_and_finish();
        $display("comparisons %0d, mismatches %0d", comparisons, n_errors);
        if (n_errors == 0 && comparisons > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : tally_and_finish

    task automatic chk_bit(input logic got, input logic exp);
        comparisons = comparisons + 1;
        if (got !== exp) begin
            n_errors = n_errors + 1;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk_bit

    task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
        comparisons = comparisons + 1;
        if (got !== exp) begin
            n_errors = n_errors + 1;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk_word

    task automatic axi_wr(input logic [7:0] a, input logic [31:0] dv, output logic [1:0] r);
        logic aw_hs, w_hs, b_hs;
        @(posedge clk_sys);
        awaddr <= a; awvalid <= 1'b1; wdata <= dv; wvalid <= 1'b1; bready <= 1'b1;
        b_hs = 1'b0;
        while (!b_hs) begin
            @(negedge clk_sys);
            aw_hs = awvalid & awready;
            w_hs = wvalid & wready;
            b_hs = bvalid;
            r = bresp;
            @(posedge clk_sys);
            if (aw_hs) awvalid <= 1'b0;
            if (w_hs) wvalid <= 1'b0;
        end
        bready <= 1'b0;
        @(posedge clk_sys);
    endtask : axi_wr

    task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        logic hs;
        @(posedge clk_sys);
        araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
        hs = 1'b0;
        while (!hs) begin
            @(negedge clk_sys);
            hs = arready;
            @(posedge clk_sys);
        end
        arvalid <= 1'b0;
        hs = 1'b0;
        while (!hs) begin
            @(negedge clk_sys);
            hs = rvalid;
            d = rdata;
            r = rresp;
            @(posedge clk_sys);
        end
        rready <= 1'b0;
        @(posedge clk_sys);
    endtask : axi_rd

    // one request per edge for n edges, data counting up from base
    task automatic stream(input logic wr, input logic rdq, input int n, input logic [7:0] base);
        @(posedge clk_sys);
        req_wr <= wr;
        req_rd <= rdq;
        for (int i = 0; i < n; i++) begin
            req_data <= base + 8'(i);
            @(posedge clk_sys);
        end
        req_wr <= 1'b0;
        req_rd <= 1'b0;
        @(posedge clk_sys);
        @(negedge clk_sys);
    endtask : stream

    initial begin
        repeat (4) @(posedge clk_sys);
        @(negedge clk_sys);
        chk_bit(full, 1'b0);
        chk_bit(empty, 1'b1);
        chk_bit(aempty, 1'b1);
        chk_bit(valid, 1'b0);
        chk_bit(wr_ack, 1'b0);
        chk_word({24'h0, data_count}, 32'h0);
        @(posedge clk_sys);
        reset_n <= 1'b1;
        repeat (6) @(posedge clk_sys);
        axi_rd(frc_pkg::OFF_STATUS, rd, rsp);
        chk_word(rd, 32'h15);
        axi_rd(frc_pkg::OFF_PFULL, rd, rsp);
        chk_word(rd, 32'hf);
        axi_rd(8'h20, rd, rsp);
        chk_word({30'h0, rsp}, {30'h0, frc_pkg::RESP_SLVERR});
        axi_wr(8'h24, 32'h1, rsp);
        chk_word({30'h0, rsp}, {30'h0, frc_pkg::RESP_SLVERR});
        // back-to-back writes then reads through the single counter
        stream(1'b1, 1'b0, 3, 8'ha0);
        chk_word({24'h0, data_count}, 32'h3);
        chk_word(n_ack, 32'h3);
        stream(1'b0, 1'b1, 3, 8'h00);
        chk_word({24'h0, got_count}, 32'h3);
        chk_word({24'h0, got_data}, 32'ha2);
        chk_bit(empty, 1'b1);
        stream(1'b0, 1'b1, 1, 8'h00);
        chk_word(n_unf, 32'h1);
        axi_rd(frc_pkg::OFF_EVENTS, rd, rsp);
        chk_word(rd, 32'h2);
        axi_wr(frc_pkg::OFF_EVENTS, 32'h2, rsp);
        stream(1'b1, 1'b0, 16, 8'h10);
        chk_bit(full, 1'b1);
        chk_bit(afull, 1'b1);
        chk_word({24'h0, data_count}, 32'h10);
        push_full <= 1'b1;
        stream(1'b1, 1'b0, 1, 8'h55);
        chk_word(n_ovf, 32'h1);
        chk_word({24'h0, data_count}, 32'h10);
        axi_rd(frc_pkg::OFF_EVENTS, rd, rsp);
        chk_word(rd, 32'h1);
        push_full <= 1'b0;
        // async reset: clears at once, full flags held high until release settles
        fifo_rst <= 1'b1;
        @(negedge clk_sys);
        chk_word({24'h0, data_count}, 32'h0);
        chk_bit(empty, 1'b1);
        chk_bit(pempty, 1'b1);
        chk_bit(full, 1'b1);
        chk_bit(pfull, 1'b1);
        @(posedge clk_sys);
        fifo_rst <= 1'b0;
        // flags stay high for three periods after the release
        for (int i = 0; i < 3; i++) begin
            @(negedge clk_sys);
            chk_bit(afull, 1'b1);
        end
        @(negedge clk_sys);
        chk_bit(full, 1'b0);
        chk_bit(afull, 1'b0);
        chk_bit(pfull, 1'b0);
        chk_word({24'h0, dout}, 32'h0);
        @(posedge clk_sys);
        stream(1'b1, 1'b0, 2, 8'h66);
        chk_word({24'h0, data_count}, 32'h2);
        axi_wr(frc_pkg::OFF_CTRL, 32'h1, rsp);
        repeat (2) @(negedge clk_sys);
        chk_word({24'h0, data_count}, 32'h0);
        chk_bit(empty, 1'b1);
        axi_rd(frc_pkg::OFF_CTRL, rd, rsp);
        chk_word(rd, 32'h0);
        tally_and_finish();
    end
endmodule : tb_top
